/* File: common/xal_defs.svh */
`ifndef XAL_DEFS_SVH
`define XAL_DEFS_SVH
// Overview of operation
// (RULE1) Decimal adjust writes W plus correction to memory
// (RULE2) Add six per nibble above nine or flagged
// (RULE3) Decrement memory; variant to W, null bit
// (RULE4) Increment memory or to W, null bit
// (RULE5) Moves between W and memory, no flags
// (RULE6) OR of W and memory, null bit only
// (RULE7) Rotate left, bit 7 into bit 0
// (RULE8) Rotate left through borrow_out_bit
// (RULE9) Rotate right, bit 0 into bit 7
// (RULE10) Rotate right through borrow_out_bit
// (RULE11) Subtract with borrow updates six flags
// (RULE12) Borrow bit clear when result negative
// (RULE13) Decrement memory, skip when zero
// (RULE14) Decrement to W, skip when W zero
// (RULE15) Increment and skip on zero, no flags
// (RULE16) Fill ones or set one bit, no flags
// (RULE17) Skip when selected bit is nonzero
// (RULE18) Write byte back, skip when nonzero
// (RULE19) Taken skip adds dummy cycle, three total
// (RULE20) Null bit set when result equals zero

`define XAL_NIB_LIMIT     4'h9
`define XAL_ADJ_NONE      8'h00
`define XAL_ADJ_LO        8'h06
`define XAL_ADJ_HI        8'h60
`define XAL_ADJ_BOTH      8'h66
`define XAL_FILL_VALUE    8'hFF
`define XAL_ONE           8'h01
`define XAL_ZERO          8'h00
`define XAL_CLK_PER_INSTR 4
`define XAL_SKIP_CYCLES   3
`define XAL_W_RESET       8'h00
`endif

/* File: common/xal_pkg.sv */
package xal_pkg;

  typedef enum logic [4:0] {
    XAL_OP_DEC_ADJ_STORE = 5'h00,
    XAL_OP_MEM_DEC       = 5'h01,
    XAL_OP_MEM_DEC_W     = 5'h02,
    XAL_OP_MEM_INC       = 5'h03,
    XAL_OP_MEM_INC_W     = 5'h04,
    XAL_OP_MOVE_TO_W     = 5'h05,
    XAL_OP_MOVE_TO_MEM   = 5'h06,
    XAL_OP_OR_TO_W       = 5'h07,
    XAL_OP_OR_TO_MEM     = 5'h08,
    XAL_OP_ROT_L         = 5'h09,
    XAL_OP_ROT_L_W       = 5'h0A,
    XAL_OP_ROT_LB        = 5'h0B,
    XAL_OP_ROT_LB_W      = 5'h0C,
    XAL_OP_ROT_R         = 5'h0D,
    XAL_OP_ROT_R_W       = 5'h0E,
    XAL_OP_ROT_RB        = 5'h0F,
    XAL_OP_ROT_RB_W      = 5'h10,
    XAL_OP_SUB_B_TO_W    = 5'h11,
    XAL_OP_SUB_B_TO_MEM  = 5'h12,
    XAL_OP_DEC_SKIP      = 5'h13,
    XAL_OP_DEC_SKIP_W    = 5'h14,
    XAL_OP_FILL_ONES     = 5'h15,
    XAL_OP_BIT_SET       = 5'h16,
    XAL_OP_INC_SKIP      = 5'h17,
    XAL_OP_INC_SKIP_W    = 5'h18,
    XAL_OP_SKIP_BIT_NZ   = 5'h19,
    XAL_OP_SKIP_BYTE_NZ  = 5'h1A
  } xal_op_t;

  typedef enum logic [3:0] {
    XAL_ST_IDLE  = 4'b0001,
    XAL_ST_FETCH = 4'b0010,
    XAL_ST_EXEC  = 4'b0100,
    XAL_ST_DUMMY = 4'b1000
  } xal_state_t;

endpackage

/* File: src/xal_tick.sv */
`include "xal_defs.svh"

module xal_tick #(
  parameter int unsigned DIV = `XAL_CLK_PER_INSTR
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          tick_ff;
  logic          nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + CW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

/* File: src/xal_calc.sv */
`include "xal_defs.svh"

module xal_calc (
  input  xal_pkg::xal_op_t op,
  input  wire logic [7:0]  m,
  input  wire logic [7:0]  w,
  input  wire logic [2:0]  bsel,
  input  wire logic        c,
  input  wire logic        ac,
  input  wire logic        cz,
  output logic      [7:0]  res,
  output logic             to_w,
  output logic             to_mem,
  output logic             upd_z,
  output logic             upd_c,
  output logic             upd_all,
  output logic             c_new,
  output logic             ac_new,
  output logic             ov_new,
  output logic             sc_new,
  output logic             cz_new,
  output logic             skip
);

  logic [8:0] diff;
  logic [4:0] lo_diff;
  logic [7:0] adj;
  logic [8:0] adj_sum;
  logic       adj_lo;
  logic       adj_hi;

  always_comb begin
    diff    = {1'b0, w} - {1'b0, m} - {8'h00, ~c}; // RULE11
    lo_diff = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
    adj_lo  = (w[3:0] > `XAL_NIB_LIMIT) || ac; // RULE2
    adj_hi  = (w[7:4] > `XAL_NIB_LIMIT) || c; // RULE2
    unique case ({adj_hi, adj_lo})
      2'b00:   adj = `XAL_ADJ_NONE;
      2'b01:   adj = `XAL_ADJ_LO;
      2'b10:   adj = `XAL_ADJ_HI;
      2'b11:   adj = `XAL_ADJ_BOTH;
    endcase
    adj_sum = {1'b0, w} + {1'b0, adj};
    res     = m;
    to_w    = 1'b0;
    to_mem  = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_all = 1'b0;
    c_new   = c;
    skip    = 1'b0;
    unique case (op)
      xal_pkg::XAL_OP_DEC_ADJ_STORE: begin
        res    = adj_sum[7:0]; // RULE1
        to_mem = 1'b1;
        upd_c  = 1'b1;
        c_new  = adj_hi | adj_sum[8];
      end
      xal_pkg::XAL_OP_MEM_DEC: begin
        res    = m - `XAL_ONE; // RULE3
        to_mem = 1'b1;
        upd_z  = 1'b1;
      end
      xal_pkg::XAL_OP_MEM_DEC_W: begin
        res   = m - `XAL_ONE; // RULE3
        to_w  = 1'b1;
        upd_z = 1'b1;
      end
      xal_pkg::XAL_OP_MEM_INC: begin
        res    = m + `XAL_ONE; // RULE4
        to_mem = 1'b1;
        upd_z  = 1'b1;
      end
      xal_pkg::XAL_OP_MEM_INC_W: begin
        res   = m + `XAL_ONE; // RULE4
        to_w  = 1'b1;
        upd_z = 1'b1;
      end
      xal_pkg::XAL_OP_MOVE_TO_W: to_w = 1'b1; // RULE5
      xal_pkg::XAL_OP_MOVE_TO_MEM: begin
        res    = w; // RULE5
        to_mem = 1'b1;
      end
      xal_pkg::XAL_OP_OR_TO_W: begin
        res   = w | m; // RULE6
        to_w  = 1'b1;
        upd_z = 1'b1;
      end
      xal_pkg::XAL_OP_OR_TO_MEM: begin
        res    = w | m; // RULE6
        to_mem = 1'b1;
        upd_z  = 1'b1;
      end
      xal_pkg::XAL_OP_ROT_L, xal_pkg::XAL_OP_ROT_L_W: begin
        res    = {m[6:0], m[7]}; // RULE7
        to_w   = (op == xal_pkg::XAL_OP_ROT_L_W);
        to_mem = (op == xal_pkg::XAL_OP_ROT_L);
      end
      xal_pkg::XAL_OP_ROT_LB, xal_pkg::XAL_OP_ROT_LB_W: begin
        res    = {m[6:0], c}; // RULE8
        c_new  = m[7];
        upd_c  = 1'b1;
        to_w   = (op == xal_pkg::XAL_OP_ROT_LB_W);
        to_mem = (op == xal_pkg::XAL_OP_ROT_LB);
      end
      xal_pkg::XAL_OP_ROT_R, xal_pkg::XAL_OP_ROT_R_W: begin
        res    = {m[0], m[7:1]}; // RULE9
        to_w   = (op == xal_pkg::XAL_OP_ROT_R_W);
        to_mem = (op == xal_pkg::XAL_OP_ROT_R);
      end
      xal_pkg::XAL_OP_ROT_RB, xal_pkg::XAL_OP_ROT_RB_W: begin
        res    = {c, m[7:1]}; // RULE10
        c_new  = m[0];
        upd_c  = 1'b1;
        to_w   = (op == xal_pkg::XAL_OP_ROT_RB_W);
        to_mem = (op == xal_pkg::XAL_OP_ROT_RB);
      end
      xal_pkg::XAL_OP_SUB_B_TO_W, xal_pkg::XAL_OP_SUB_B_TO_MEM: begin
        res     = diff[7:0]; // RULE11
        c_new   = ~diff[8]; // RULE12
        upd_c   = 1'b1;
        upd_z   = 1'b1;
        upd_all = 1'b1;
        to_w    = (op == xal_pkg::XAL_OP_SUB_B_TO_W);
        to_mem  = (op == xal_pkg::XAL_OP_SUB_B_TO_MEM);
      end
      xal_pkg::XAL_OP_DEC_SKIP: begin
        res    = m - `XAL_ONE; // RULE13
        to_mem = 1'b1;
        skip   = (res == `XAL_ZERO);
      end
      xal_pkg::XAL_OP_DEC_SKIP_W: begin
        res  = m - `XAL_ONE; // RULE14
        to_w = 1'b1;
        skip = (res == `XAL_ZERO);
      end
      xal_pkg::XAL_OP_INC_SKIP: begin
        res    = m + `XAL_ONE; // RULE15
        to_mem = 1'b1;
        skip   = (res == `XAL_ZERO);
      end
      xal_pkg::XAL_OP_INC_SKIP_W: begin
        res  = m + `XAL_ONE; // RULE15
        to_w = 1'b1;
        skip = (res == `XAL_ZERO);
      end
      xal_pkg::XAL_OP_FILL_ONES: begin
        res    = `XAL_FILL_VALUE; // RULE16
        to_mem = 1'b1;
      end
      xal_pkg::XAL_OP_BIT_SET: begin
        res       = m; // RULE16
        res[bsel] = 1'b1;
        to_mem    = 1'b1;
      end
      xal_pkg::XAL_OP_SKIP_BIT_NZ: skip = m[bsel]; // RULE17
      xal_pkg::XAL_OP_SKIP_BYTE_NZ: begin
        to_mem = 1'b1; // RULE18
        skip   = (m != `XAL_ZERO);
      end
      default: res = m;
    endcase
    ac_new = ~lo_diff[4];
    ov_new = (w[7] ^ m[7]) & (w[7] ^ diff[7]);
    sc_new = ~(ov_new ^ diff[7]);
    cz_new = (diff[7:0] == `XAL_ZERO) & cz;
  end

endmodule

/* File: src/xal_core.sv */
`include "xal_defs.svh"

module xal_core #(
  parameter int unsigned CLK_PER_INSTR = `XAL_CLK_PER_INSTR
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        op_valid,
  input  xal_pkg::xal_op_t op_code,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [2:0]  bit_sel,
  input  wire logic        w_load,
  input  wire logic [7:0]  w_load_data,
  output logic             op_ready,
  output logic             mem_we,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  working_register,
  output logic             borrow_out_bit,
  output logic             half_borrow_bit,
  output logic             null_result_bit,
  output logic             signed_range_bit,
  output logic             sign_compare_bit,
  output logic             chained_zero_bit,
  output logic             skip_taken,
  output logic             dummy_cycle,
  output logic             op_done
);

  // Instruction cycle strobe
  logic tick;

  xal_tick #(
    .DIV (CLK_PER_INSTR)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Captured instruction and operands
  xal_pkg::xal_state_t state_ff;
  xal_pkg::xal_state_t nxt_state;
  xal_pkg::xal_op_t    op_ff;
  xal_pkg::xal_op_t    nxt_op;
  logic [7:0]          m_ff;
  logic [7:0]          nxt_m;
  logic [2:0]          bsel_ff;
  logic [2:0]          nxt_bsel;

  // Architectural state
  logic [7:0] w_ff;
  logic [7:0] nxt_w;
  logic       c_ff;
  logic       nxt_c;
  logic       ac_ff;
  logic       nxt_ac;
  logic       z_ff;
  logic       nxt_z;
  logic       ov_ff;
  logic       nxt_ov;
  logic       sc_ff;
  logic       nxt_sc;
  logic       cz_ff;
  logic       nxt_cz;

  // Port side registers
  logic       ready_ff;
  logic       nxt_ready;
  logic       we_ff;
  logic       nxt_we;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic       skip_ff;
  logic       nxt_skip;
  logic       dummy_ff;
  logic       nxt_dummy;
  logic       done_ff;
  logic       nxt_done;

  // Datapath results
  logic [7:0] res;
  logic       to_w;
  logic       to_mem;
  logic       upd_z;
  logic       upd_c;
  logic       upd_all;
  logic       c_new;
  logic       ac_new;
  logic       ov_new;
  logic       sc_new;
  logic       cz_new;
  logic       skip;
  logic       commit;

  xal_calc u_calc (
    .op      (op_ff),
    .m       (m_ff),
    .w       (w_ff),
    .bsel    (bsel_ff),
    .c       (c_ff),
    .ac      (ac_ff),
    .cz      (cz_ff),
    .res     (res),
    .to_w    (to_w),
    .to_mem  (to_mem),
    .upd_z   (upd_z),
    .upd_c   (upd_c),
    .upd_all (upd_all),
    .c_new   (c_new),
    .ac_new  (ac_new),
    .ov_new  (ov_new),
    .sc_new  (sc_new),
    .cz_new  (cz_new),
    .skip    (skip)
  );

  // Sequencer: fetch, execute, and a dummy cycle after a taken skip
  always_comb begin
    nxt_state = state_ff;
    nxt_op    = op_ff;
    nxt_m     = m_ff;
    nxt_bsel  = bsel_ff;
    nxt_ready = 1'b0;
    nxt_done  = 1'b0;
    nxt_dummy = 1'b0;
    commit    = 1'b0;
    unique case (state_ff)
      xal_pkg::XAL_ST_IDLE: begin
        nxt_ready = 1'b1;
        if (op_valid) begin
          nxt_state = xal_pkg::XAL_ST_FETCH;
          nxt_op    = op_code;
          nxt_m     = mem_rdata;
          nxt_bsel  = bit_sel;
          nxt_ready = 1'b0;
        end
      end
      xal_pkg::XAL_ST_FETCH: begin
        if (tick) begin
          nxt_state = xal_pkg::XAL_ST_EXEC;
        end
      end
      xal_pkg::XAL_ST_EXEC: begin
        if (tick) begin
          commit = 1'b1;
          if (skip) begin
            nxt_state = xal_pkg::XAL_ST_DUMMY; // RULE19
            nxt_dummy = 1'b1;
          end else begin
            nxt_state = xal_pkg::XAL_ST_IDLE;
            nxt_done  = 1'b1;
            nxt_ready = 1'b1;
          end
        end
      end
      xal_pkg::XAL_ST_DUMMY: begin
        nxt_dummy = 1'b1;
        if (tick) begin
          nxt_state = xal_pkg::XAL_ST_IDLE; // RULE19
          nxt_done  = 1'b1;
          nxt_ready = 1'b1;
          nxt_dummy = 1'b0;
        end
      end
      default: begin
        nxt_state = xal_pkg::XAL_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= xal_pkg::XAL_ST_IDLE;
      op_ff    <= xal_pkg::XAL_OP_MOVE_TO_W;
      m_ff     <= `XAL_ZERO;
      bsel_ff  <= 3'h0;
      ready_ff <= 1'b0;
      done_ff  <= 1'b0;
      dummy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      m_ff     <= nxt_m;
      bsel_ff  <= nxt_bsel;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
      dummy_ff <= nxt_dummy;
    end
  end

  // Working register, status bits and memory write strobe
  always_comb begin
    nxt_w     = w_ff;
    nxt_c     = c_ff;
    nxt_ac    = ac_ff;
    nxt_z     = z_ff;
    nxt_ov    = ov_ff;
    nxt_sc    = sc_ff;
    nxt_cz    = cz_ff;
    nxt_we    = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_skip  = 1'b0;
    if (commit) begin
      if (to_w) begin
        nxt_w = res; // RULE3
      end
      if (to_mem) begin
        nxt_we    = 1'b1; // RULE18
        nxt_wdata = res;
      end
      if (upd_z) begin
        nxt_z = (res == `XAL_ZERO); // RULE20
      end
      if (upd_c) begin
        nxt_c = c_new; // RULE12
      end
      if (upd_all) begin
        nxt_ac = ac_new; // RULE11
        nxt_ov = ov_new;
        nxt_sc = sc_new;
        nxt_cz = cz_new;
      end
      nxt_skip = skip; // RULE17
    end else if (w_load && (state_ff == xal_pkg::XAL_ST_IDLE)) begin
      nxt_w = w_load_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_ff     <= `XAL_W_RESET;
      c_ff     <= 1'b0;
      ac_ff    <= 1'b0;
      z_ff     <= 1'b0;
      ov_ff    <= 1'b0;
      sc_ff    <= 1'b0;
      cz_ff    <= 1'b0;
      we_ff    <= 1'b0;
      wdata_ff <= `XAL_ZERO;
      skip_ff  <= 1'b0;
    end else begin
      w_ff     <= nxt_w;
      c_ff     <= nxt_c;
      ac_ff    <= nxt_ac;
      z_ff     <= nxt_z;
      ov_ff    <= nxt_ov;
      sc_ff    <= nxt_sc;
      cz_ff    <= nxt_cz;
      we_ff    <= nxt_we;
      wdata_ff <= nxt_wdata;
      skip_ff  <= nxt_skip;
    end
  end

  assign op_ready         = ready_ff;
  assign mem_we           = we_ff;
  assign mem_wdata        = wdata_ff;
  assign working_register = w_ff;
  assign borrow_out_bit   = c_ff;
  assign half_borrow_bit  = ac_ff;
  assign null_result_bit  = z_ff;
  assign signed_range_bit = ov_ff;
  assign sign_compare_bit = sc_ff;
  assign chained_zero_bit = cz_ff;
  assign skip_taken       = skip_ff;
  assign dummy_cycle      = dummy_ff;
  assign op_done          = done_ff;

endmodule

/* File: test/xal_core_chk.sv */
module xal_core_chk #(
  parameter int unsigned CLK_PER_INSTR = 4
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        op_valid,
  input xal_pkg::xal_op_t op_code,
  input wire logic [7:0]  mem_rdata,
  input wire logic [2:0]  bit_sel,
  input wire logic        op_ready,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic        borrow_out_bit,
  input wire logic        null_result_bit,
  input wire logic        skip_taken,
  input wire logic        dummy_cycle,
  input wire logic        op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SKW  = CLK_PER_INSTR;
  localparam int MAXW = 3 * CLK_PER_INSTR + 1;
  xal_pkg::xal_op_t op_ff;
  logic [7:0]       m_ff;
  logic [2:0]       b_ff;
  logic [1:0]       f_ff;
  logic             exp_skip;
  logic             no_flags;
  // Operands of the instruction in flight, captured on acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= xal_pkg::XAL_OP_DEC_ADJ_STORE;
      m_ff  <= 8'h00;
      b_ff  <= 3'h0;
      f_ff  <= 2'h0;
    end else if (op_valid && op_ready) begin
      op_ff <= op_code;
      m_ff  <= mem_rdata;
      b_ff  <= bit_sel;
      f_ff  <= {borrow_out_bit, null_result_bit};
    end
  end
  assign exp_skip = (op_ff == xal_pkg::XAL_OP_SKIP_BIT_NZ && m_ff[b_ff])
    || (op_ff == xal_pkg::XAL_OP_SKIP_BYTE_NZ && m_ff != 8'h00)
    || (op_ff inside {xal_pkg::XAL_OP_DEC_SKIP, xal_pkg::XAL_OP_DEC_SKIP_W} && m_ff == 8'h01)
    || (op_ff inside {xal_pkg::XAL_OP_INC_SKIP, xal_pkg::XAL_OP_INC_SKIP_W} && m_ff == 8'hFF);
  assign no_flags = op_ff inside {xal_pkg::XAL_OP_MOVE_TO_W, xal_pkg::XAL_OP_MOVE_TO_MEM,
    xal_pkg::XAL_OP_ROT_L, xal_pkg::XAL_OP_ROT_L_W, xal_pkg::XAL_OP_ROT_R,
    xal_pkg::XAL_OP_ROT_R_W, xal_pkg::XAL_OP_FILL_ONES, xal_pkg::XAL_OP_BIT_SET,
    xal_pkg::XAL_OP_DEC_SKIP, xal_pkg::XAL_OP_DEC_SKIP_W, xal_pkg::XAL_OP_INC_SKIP,
    xal_pkg::XAL_OP_INC_SKIP_W, xal_pkg::XAL_OP_SKIP_BIT_NZ, xal_pkg::XAL_OP_SKIP_BYTE_NZ};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_drop: assert property (op_valid && op_ready |=> !op_ready)
    else $error("op_ready stayed high after acceptance");
  a_done_bound: assert property (op_valid && op_ready |-> ##[2:MAXW] op_done)
    else $error("instruction did not finish in time");
  a_skip_gap: assert property (skip_taken |-> dummy_cycle ##[SKW:SKW] op_done)
    else $error("dummy cycle not one instruction long");
  a_skip_cause: assert property (skip_taken |-> exp_skip)
    else $error("skip taken without cause");
  a_noskip_cause: assert property (op_done && !$past(dummy_cycle) |-> !exp_skip)
    else $error("skip missed");
  a_fill_ones: assert property (mem_we && op_ff == xal_pkg::XAL_OP_FILL_ONES
    |-> mem_wdata == 8'hFF)
    else $error("fill value wrong");
  a_bit_set: assert property (mem_we && op_ff == xal_pkg::XAL_OP_BIT_SET
    |-> mem_wdata == (m_ff | (8'h01 << b_ff)))
    else $error("bit set value wrong");
  a_rot_left: assert property (mem_we && op_ff == xal_pkg::XAL_OP_ROT_L
    |-> mem_wdata == {m_ff[6:0], m_ff[7]})
    else $error("rotate left value wrong");
  a_rot_right: assert property (mem_we && op_ff == xal_pkg::XAL_OP_ROT_R
    |-> mem_wdata == {m_ff[0], m_ff[7:1]})
    else $error("rotate right value wrong");
  a_byte_back: assert property (mem_we && op_ff == xal_pkg::XAL_OP_SKIP_BYTE_NZ
    |-> mem_wdata == m_ff)
    else $error("byte not written back");
  a_flags_kept: assert property (op_done && no_flags
    |-> {borrow_out_bit, null_result_bit} == f_ff)
    else $error("status changed by flag-free op");
  c_skip: cover property (skip_taken);
  c_refused: cover property (op_valid && !op_ready);
  c_set: cover property (mem_we && op_ff == xal_pkg::XAL_OP_BIT_SET);
endmodule

bind xal_core xal_core_chk #(.CLK_PER_INSTR(CLK_PER_INSTR)) xal_core_chk_i (
  .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .mem_rdata(mem_rdata),
  .bit_sel(bit_sel), .op_ready(op_ready), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .borrow_out_bit(borrow_out_bit), .null_result_bit(null_result_bit),
  .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .op_done(op_done)
);

/* File: test/extended_data_memory_alu_ops_tb.sv */
module extended_data_memory_alu_ops_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DIV = 2;
  // Per op, highest first: {to mem, to W, null bit, skip on zero}
  localparam logic [107:0] CTL = 108'h805988598448484848A6846A6A8;
  logic             clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             op_valid = 1'h0;
  xal_pkg::xal_op_t op_code = xal_pkg::XAL_OP_DEC_ADJ_STORE;
  logic [7:0]       mem_rdata = 8'h00;
  logic [2:0]       bit_sel = 3'h0;
  logic             w_load = 1'h0;
  logic [7:0]       w_load_data = 8'h00;
  logic             op_ready, mem_we, skip_taken, dummy_cycle, op_done;
  logic [7:0]       mem_wdata, working_register, w_exp;
  logic             borrow_out_bit, half_borrow_bit, null_result_bit;
  logic             signed_range_bit, sign_compare_bit, chained_zero_bit;
  logic [5:0]       flags, f_exp;
  logic [31:0]      seed = 32'h0000004C;
  logic [7:0]       mt [4] = '{8'h00, 8'h01, 8'hFF, 8'h9A};
  logic [7:0]       wt [4] = '{8'h00, 8'h01, 8'h99, 8'h9A};
  logic [2:0]       bt [4] = '{3'h0, 3'h0, 3'h7, 3'h2};
  int               miscompares = 0;
  int               checked = 0;

  assign flags = {borrow_out_bit, half_borrow_bit, null_result_bit,
                  signed_range_bit, sign_compare_bit, chained_zero_bit};
  always #25 clk = ~clk;

  xal_core #(.CLK_PER_INSTR(DIV)) xal_core_i (
    .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .mem_rdata(mem_rdata),
    .bit_sel(bit_sel), .w_load(w_load), .w_load_data(w_load_data), .op_ready(op_ready),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .working_register(working_register),
    .borrow_out_bit(borrow_out_bit), .half_borrow_bit(half_borrow_bit),
    .null_result_bit(null_result_bit), .signed_range_bit(signed_range_bit),
    .sign_compare_bit(sign_compare_bit), .chained_zero_bit(chained_zero_bit),
    .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .op_done(op_done)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic void calc(input xal_pkg::xal_op_t op, input logic [7:0] m,
                               input logic [2:0] b, output logic we, output logic [7:0] wd,
                               output logic sk);
    logic [7:0] adj, r;
    logic [8:0] a9, d9;
    logic [4:0] h5;
    logic       tw, zf, sz, ov;
    adj[7:4] = (w_exp[7:4] > 4'h9 || f_exp[5]) ? 4'h6 : 4'h0;
    adj[3:0] = (w_exp[3:0] > 4'h9 || f_exp[4]) ? 4'h6 : 4'h0;
    a9 = {1'h0, w_exp} + {1'h0, adj};
    d9 = {1'h0, w_exp} - {1'h0, m} - {8'h00, ~f_exp[5]};
    h5 = {1'h0, w_exp[3:0]} - {1'h0, m[3:0]} - {4'h0, ~f_exp[5]};
    {we, tw, zf, sz} = CTL[4 * int'(op) +: 4];
    case (op)
      xal_pkg::XAL_OP_DEC_ADJ_STORE: r = a9[7:0];
      xal_pkg::XAL_OP_MEM_DEC, xal_pkg::XAL_OP_MEM_DEC_W,
      xal_pkg::XAL_OP_DEC_SKIP, xal_pkg::XAL_OP_DEC_SKIP_W: r = m - 8'h01;
      xal_pkg::XAL_OP_MEM_INC, xal_pkg::XAL_OP_MEM_INC_W,
      xal_pkg::XAL_OP_INC_SKIP, xal_pkg::XAL_OP_INC_SKIP_W: r = m + 8'h01;
      xal_pkg::XAL_OP_MOVE_TO_MEM: r = w_exp;
      xal_pkg::XAL_OP_OR_TO_W, xal_pkg::XAL_OP_OR_TO_MEM: r = w_exp | m;
      xal_pkg::XAL_OP_ROT_L, xal_pkg::XAL_OP_ROT_L_W: r = {m[6:0], m[7]};
      xal_pkg::XAL_OP_ROT_LB, xal_pkg::XAL_OP_ROT_LB_W: r = {m[6:0], f_exp[5]};
      xal_pkg::XAL_OP_ROT_R, xal_pkg::XAL_OP_ROT_R_W: r = {m[0], m[7:1]};
      xal_pkg::XAL_OP_ROT_RB, xal_pkg::XAL_OP_ROT_RB_W: r = {f_exp[5], m[7:1]};
      xal_pkg::XAL_OP_SUB_B_TO_W, xal_pkg::XAL_OP_SUB_B_TO_MEM: r = d9[7:0];
      xal_pkg::XAL_OP_FILL_ONES: r = 8'hFF;
      xal_pkg::XAL_OP_BIT_SET: r = m | (8'h01 << b);
      default: r = m;
    endcase
    ov = (w_exp[7] ^ m[7]) & (d9[7] ^ w_exp[7]);
    sk = (sz && r == 8'h00) || (op == xal_pkg::XAL_OP_SKIP_BIT_NZ && m[b])
      || (op == xal_pkg::XAL_OP_SKIP_BYTE_NZ && m != 8'h00);
    wd = r;
    if (op == xal_pkg::XAL_OP_DEC_ADJ_STORE) f_exp[5] = adj[5] | a9[8];
    if (op inside {xal_pkg::XAL_OP_ROT_LB, xal_pkg::XAL_OP_ROT_LB_W}) f_exp[5] = m[7];
    if (op inside {xal_pkg::XAL_OP_ROT_RB, xal_pkg::XAL_OP_ROT_RB_W}) f_exp[5] = m[0];
    if (zf) f_exp[3] = (r == 8'h00);
    if (op inside {xal_pkg::XAL_OP_SUB_B_TO_W, xal_pkg::XAL_OP_SUB_B_TO_MEM}) f_exp =
      {~d9[8], ~h5[4], r == 8'h00, ov, ~(ov ^ r[7]), r == 8'h00 && f_exp[0]};
    if (tw) w_exp = r;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Loads W, issues one op, optionally repeats the request while busy
  task automatic run_op(input xal_pkg::xal_op_t op, input logic [7:0] m, input logic [2:0] b,
                        input logic [7:0] wv, input logic poke);
    logic       we_s, we_e, sk_e;
    logic [7:0] wd_s, wd_e;
    int         n, ks;
    we_s = 1'h0;
    wd_s = 8'h00;
    ks = 0;
    @(posedge clk);
    w_load <= 1'h1;
    w_load_data <= wv;
    @(posedge clk);
    w_load <= 1'h0;
    op_valid <= 1'h1;
    op_code <= op;
    mem_rdata <= m;
    bit_sel <= b;
    @(posedge clk);
    op_valid <= poke;
    mem_rdata <= ~m;
    bit_sel <= ~b;
    for (n = 1; n < 40; n++) begin
      @(posedge clk);
      op_valid <= 1'h0;
      #1;
      if (mem_we === 1'h1) we_s = 1'h1;
      if (mem_we === 1'h1) wd_s = mem_wdata;
      if (skip_taken === 1'h1) ks = n;
      if (skip_taken === 1'h1) check(dummy_cycle, 1'h1);
      if (op_done === 1'h1) break;
    end
    w_exp = wv;
    calc(op, m, b, we_e, wd_e, sk_e);
    check(op_done, 1'h1);
    check(we_s, we_e);
    if (we_e) check(wd_s, wd_e);
    check(working_register, w_exp);
    check({2'h0, flags}, {2'h0, f_exp});
    check(ks != 0, sk_e);
    if (sk_e) check(8'(n - ks), 8'(DIV));
    else check(n <= 2 * DIV + 1, 1'h1);
  endtask

  initial begin : main
    logic [31:0] r;
    repeat (8) @(posedge clk);
    check(working_register, 8'h00);
    check({2'h0, flags}, 8'h00);
    check(op_ready, 1'h0);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    check(op_ready, 1'h1);
    w_exp = 8'h00;
    f_exp = 6'h00;
    for (int i = 0; i < 27; i++) begin
      for (int j = 0; j < 4; j++) begin
        run_op(xal_pkg::xal_op_t'(i[4:0]), mt[j], bt[j], wt[j], 1'h0);
      end
    end
    repeat (400) begin
      r = rnd();
      run_op(xal_pkg::xal_op_t'(5'(r % 27)), r[15:8], r[18:16], r[31:24], r[19]);
    end
    test_done();
  end

  initial begin : watchdog
    repeat (30000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
